// ==== rtl/admr_regs.sv ====
// Mode control register bank for a stereo audio converter
`timescale 1ns/1ns
module admr_regs
  import admr_pkg::*;
#(
  parameter logic [CHIPNUM_W-1:0] CHIP_NUMBER = 5'h00 // Value is arbitrary
)(
  input  wire logic        sys_clk,          // System clock, 10 MHz
  input  wire logic        rst,              // Asynchronous reset
  input  wire logic [15:0] cmdWord,          // Control word from port
  input  wire logic        cmdValid,         // Word strobe, one cycle
  input  wire logic        wordClockTick,    // One pulse per frame
  input  wire logic        leftZeroIn,       // Left zero detected
  input  wire logic        rightZeroIn,      // Right zero detected
  output logic      [15:0] readWord,         // Readback word
  output logic             readValid,        // Readback strobe
  output logic      [7:0]  leftLevelCode,    // Active left level
  output logic      [7:0]  rightLevelCode,   // Active right level
  output logic             leftMuted,        // Left fully muted
  output logic             rightMuted,       // Right fully muted
  output logic      [2:0]  serialFormatSelect, // Audio format
  output logic      [1:0]  deemphRateSelect, // De-emphasis rate
  output logic      [1:0]  analogFirPerf,    // One-bit FIR performance
  output logic             deemphEnable,     // De-emphasis on
  output logic             softMute,         // Soft mute request
  output logic             phaseInvert,      // Output phase reversed
  output logic             outputDisable,    // Analog outputs off
  output logic             bypassStereoSelect, // Stereo in bypass
  output logic             rolloffSelect,    // Slow roll-off
  output logic             endlessZeroMute,  // Endless zero mute on
  output logic             softResetCtrl,    // Core held in reset
  output logic             oneBitStreamMode, // One-bit mode active
  output logic             filterBypass,     // Filter bypass active
  output logic             singleChannelMode, // Single_channel_mode operation
  output logic             singleChannelPick, // Single_channel_mode source right
  output logic      [1:0]  oversamplingRate, // Sample-mode rate
  output logic      [1:0]  analogFirRate,    // One-bit FIR rate
  output logic             sampleZeroOutputEnable, // Zero pins, sample
  output logic      [1:0]  onebitZeroOutput  // Zero pins, one-bit
);
  // Stored register contents
  logic [7:0] leftLevel;        // Written left code
  logic [7:0] rightLevel;       // Written right code
  logic [7:0] formatReg;        // Format and de-emphasis
  logic [7:0] outputReg;        // Output and filter options
  logic [7:0] modeReg;          // Interface mode control
  logic [7:0] zeroCtrlReg;      // Zero output control
  logic [7:0] leftTarget;       // Loaded left target
  logic [7:0] rightTarget;      // Loaded right target
  logic [2:0] rampCount;        // Word clock divider
  logic       leftZeroFlag;     // Registered left flag
  logic       rightZeroFlag;    // Registered right flag

  // Overview of the bank
  // Every control word arrives whole, already framed by the serial
  // port logic, and is presented for exactly one clock with its
  // strobe. This block never sees individual serial bits, so it
  // holds no shift register and no bit counter of its own.
  //
  // A word is taken on the edge where the strobe is high and the
  // top three index bits hold the common prefix. Words with another
  // prefix belong to other devices or to unused space and are let
  // pass with no effect, which keeps a shared port harmless.
  //
  // Writes land in the stored register on the taking edge. Reads
  // answer one clock later with the request's upper byte echoed,
  // so the port logic can frame the reply without remembering the
  // index itself.
  //
  // Hazard: a read and a write cannot share one word, so a read
  // always returns the value as it stood before that edge. The
  // answer is therefore never a mix of old and new bits.
  //
  // Limitation: registers 22 and 23 have no write strobe at all.
  // A write to them is decoded, found to match no writable entry,
  // and dropped; nothing tells the host that it was refused.
  //
  // Attenuation path
  // The level registers hold whatever the host wrote, so a read
  // always shows the last written code. The loaded targets are a
  // second copy that only follows writes made while the shared
  // load enable is set. The ramp units chase the loaded targets,
  // one code per step tick, so the output never jumps.
  //
  // Trade-off: keeping a separate stored copy costs sixteen flops,
  // and codes staged with the load enable clear are not released by
  // setting it afterwards; each must be written again while it is set.
  //
  // Step rate
  // The word clock arrives as a one-cycle tick. A small counter of
  // ticks, masked by the ramp rate select, thins it down to one
  // step every one, two, four or eight frames. The counter is free
  // running; a change of rate therefore takes effect at once and
  // the first step after it may come early by up to seven frames.
  //
  // Soft mute drives both ramps toward code zero at the same rate.
  // Clearing it lets them climb back toward the loaded targets.
  //
  // Mode interplay
  // One-bit stream mode and filter bypass exclude each other. When
  // both bits are set neither mode is reported active, so the core
  // falls back to normal sample mode rather than guessing which one
  // the host meant. Each bit still reads back as written.
  //
  // In one-bit mode the de-emphasis rate field and the oversampling
  // field are handed to the analog filter outputs instead, and the
  // sample-mode outputs of those fields are forced to zero, so no
  // downstream logic sees a stale meaning of the same bits.
  //
  // Reserved positions are masked on every write, so they read
  // zero whatever the host tries. The masks live in the package
  // beside the reset values to keep the two in step.
  //
  // Zero detection
  // The flag inputs come from logic on this same clock, so they are
  // registered once and need no synchroniser. A flag that rises for
  // a single clock can be missed by a read that lands a cycle late;
  // the detector upstream is expected to hold its level.
  //
  // Chip number
  // The device number for the time-division mode is a parameter.
  // It is returned in the low five bits of the last register, with
  // the three upper bits reading zero like any reserved position.
  //
  // Reset
  // All storage clears asynchronously to the documented defaults.
  // The level outputs restart at full scale, which matches the
  // level registers, so no ramp runs right after reset.

  // Field decode of the incoming word
  wire        isRead    = cmdWord[DIR_BIT];
  wire [6:0]  regIndex  = cmdWord[IDX_HI:IDX_LO];
  wire [7:0]  wrData    = cmdWord[7:0];
  wire        prefixOk  = (cmdWord[IDX_HI:IDX_PFX_LO] == INDEX_PREFIX);
  wire        doWrite   = cmdValid && !isRead && prefixOk;
  wire        doRead    = cmdValid && isRead && prefixOk;

  // Per-register write strobes; 22 and 23 have none
  wire wrLeft  = doWrite && (regIndex == REG_LEFT_LEVEL);
  wire wrRight = doWrite && (regIndex == REG_RIGHT_LEVEL);
  wire wrFmt   = doWrite && (regIndex == REG_FORMAT);
  wire wrOut   = doWrite && (regIndex == REG_OUTPUT);
  wire wrMode  = doWrite && (regIndex == REG_MODE);
  wire wrZero  = doWrite && (regIndex == REG_ZERO_CTRL);

  // Shared load enable gates level updates
  wire loadEnable = formatReg[LOAD_EN_BIT];

  // Readback multiplexer
  function automatic logic [7:0] read_mux(input logic [6:0] idx);
    case (idx)
      REG_LEFT_LEVEL:  read_mux = leftLevel;
      REG_RIGHT_LEVEL: read_mux = rightLevel;
      REG_FORMAT:      read_mux = formatReg;
      REG_OUTPUT:      read_mux = outputReg;
      REG_MODE:        read_mux = modeReg;
      REG_ZERO_CTRL:   read_mux = zeroCtrlReg;
      REG_ZERO_STAT:   read_mux = {6'h00, rightZeroFlag, leftZeroFlag};
      REG_CHIP_NUM:    read_mux = {3'h0, CHIP_NUMBER};
      default:         read_mux = 8'h00;
    endcase
  endfunction

  // Level registers reset to full scale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leftLevel  <= LEVEL_RESET;
      rightLevel <= LEVEL_RESET;
    end else begin
      if (wrLeft) begin
        leftLevel <= wrData;
      end
      if (wrRight) begin
        rightLevel <= wrData;
      end
    end
  end

  // Loaded targets only follow writes made with load enabled
  // The stored code stays readable even when not loaded
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leftTarget  <= LEVEL_RESET;
      rightTarget <= LEVEL_RESET;
    end else begin
      if (wrLeft && loadEnable) begin
        leftTarget <= wrData;
      end
      if (wrRight && loadEnable) begin
        rightTarget <= wrData;
      end
    end
  end

  // Control registers; reserved bits masked to zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      formatReg   <= FORMAT_RESET;
      outputReg   <= OUTPUT_RESET;
      modeReg     <= MODE_RESET;
      zeroCtrlReg <= ZERO_CTRL_RESET;
    end else begin
      if (wrFmt) begin
        formatReg <= wrData & FORMAT_MASK;
      end
      if (wrOut) begin
        outputReg <= wrData & OUTPUT_MASK;
      end
      if (wrMode) begin
        modeReg <= wrData & MODE_MASK;
      end
      if (wrZero) begin
        zeroCtrlReg <= wrData & ZERO_CTRL_MASK;
      end
    end
  end

  // Zero detect flags are sampled; inputs come from same clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leftZeroFlag  <= 1'b0;
      rightZeroFlag <= 1'b0;
    end else begin
      leftZeroFlag  <= leftZeroIn;
      rightZeroFlag <= rightZeroIn;
    end
  end

  // Readback answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readWord  <= 16'h0000;
      readValid <= 1'b0;
    end else begin
      readValid <= doRead;
      if (doRead) begin
        readWord <= {cmdWord[15:8], read_mux(regIndex)};
      end
    end
  end

  // Word clock divider for the ramp rate
  wire [1:0] rampSel = outputReg[RAMP_LO +: 2];
  wire [2:0] rampMask = 3'((4'h1 << rampSel) - 4'h1);
  wire       stepTick = wordClockTick && ((rampCount & rampMask) == 3'h0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rampCount <= 3'h0;
    end else if (wordClockTick) begin
      rampCount <= rampCount + 3'h1;
    end
  end

  // Soft mute ramps both channels toward zero code
  assign softMute = formatReg[0];

  admr_level_ramp u_left (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .stepTick (stepTick),
    .muteReq  (softMute),
    .target   (leftTarget),
    .level    (leftLevelCode),
    .muted    (leftMuted)
  );

  admr_level_ramp u_right (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .stepTick (stepTick),
    .muteReq  (softMute),
    .target   (rightTarget),
    .level    (rightLevelCode),
    .muted    (rightMuted)
  );

  // Mode field decode
  wire modeOneBit = modeReg[ONEBIT_BIT];
  wire modeBypass = modeReg[BYPASS_BIT];

  // Neither mode wins; both are reported inactive while both bits are set
  assign oneBitStreamMode = modeOneBit && !modeBypass;
  assign filterBypass     = modeBypass && !modeOneBit;

  // Format register fields; rate field reused in one-bit mode
  assign serialFormatSelect = formatReg[6:4];
  assign deemphRateSelect   = oneBitStreamMode ? 2'h0
                              : formatReg[DEEMPH_LO +: 2];
  assign analogFirPerf      = oneBitStreamMode ?
                              formatReg[DEEMPH_LO +: 2] : 2'h0;
  assign deemphEnable       = formatReg[1];

  // Output option fields
  assign phaseInvert        = outputReg[7];
  assign outputDisable      = outputReg[4];
  assign bypassStereoSelect = outputReg[2];
  assign rolloffSelect      = outputReg[1];
  // Active in sample and bypass modes only
  assign endlessZeroMute    = outputReg[ENDLESS_BIT] && !oneBitStreamMode;

  // Soft reset bit: 1 is normal, 0 holds reset in all modes
  assign softResetCtrl      = !modeReg[SOFT_RST_BIT];
  assign singleChannelMode  = modeReg[SINGLE_BIT];
  assign singleChannelPick  = modeReg[PICK_BIT];
  // Rate field meaning depends on one-bit mode
  assign oversamplingRate   = oneBitStreamMode ? 2'h0
                              : modeReg[OSR_LO +: 2];
  assign analogFirRate      = oneBitStreamMode ?
                              modeReg[OSR_LO +: 2] : 2'h0;

  // Zero output controls
  assign sampleZeroOutputEnable = zeroCtrlReg[SZERO_BIT];
  assign onebitZeroOutput       = zeroCtrlReg[OZERO_LO +: 2];

  // Chip number readable by index 23 only
endmodule

// ==== rtl/admr_pkg.sv ====
// Constants shared by the converter mode register bank
package admr_pkg;
  // Register indices within the 7-bit index field
  localparam logic [6:0] REG_LEFT_LEVEL  = 7'h10;
  localparam logic [6:0] REG_RIGHT_LEVEL = 7'h11;
  localparam logic [6:0] REG_FORMAT      = 7'h12;
  localparam logic [6:0] REG_OUTPUT      = 7'h13;
  localparam logic [6:0] REG_MODE        = 7'h14;
  localparam logic [6:0] REG_ZERO_CTRL   = 7'h15;
  localparam logic [6:0] REG_ZERO_STAT   = 7'h16;
  localparam logic [6:0] REG_CHIP_NUM    = 7'h17;
  // Upper three index bits common to every register
  localparam logic [2:0] INDEX_PREFIX    = 3'h1;
  // Word layout
  localparam int DIR_BIT  = 15;
  localparam int IDX_HI   = 14;
  localparam int IDX_LO   = 8;
  localparam int IDX_PFX_LO = 12;
  // Reset values
  localparam logic [7:0] LEVEL_RESET     = 8'hff;
  localparam logic [7:0] FORMAT_RESET    = 8'h50;
  localparam logic [7:0] OUTPUT_RESET    = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h40;
  localparam logic [7:0] ZERO_CTRL_RESET = 8'h01;
  // Writable bit masks; reserved positions are held at zero
  localparam logic [7:0] FORMAT_MASK     = 8'hff;
  localparam logic [7:0] OUTPUT_MASK     = 8'hf7;
  localparam logic [7:0] MODE_MASK       = 8'h7f;
  localparam logic [7:0] ZERO_CTRL_MASK  = 8'h07;
  // Field positions
  localparam int LOAD_EN_BIT   = 7;
  localparam int DEEMPH_LO     = 2;
  localparam int RAMP_LO       = 5;
  localparam int ENDLESS_BIT   = 0;
  localparam int SOFT_RST_BIT  = 6;
  localparam int ONEBIT_BIT    = 5;
  localparam int BYPASS_BIT    = 4;
  localparam int SINGLE_BIT    = 3;
  localparam int PICK_BIT      = 2;
  localparam int OSR_LO        = 0;
  localparam int SZERO_BIT     = 0;
  localparam int OZERO_LO      = 1;
  localparam int CHIPNUM_W     = 5;
  // Codes at or below this give full mute
  localparam logic [7:0] MUTE_CODE_MAX   = 8'h0e;
  localparam logic [7:0] ZERO_CODE       = 8'h00;
endpackage

// ==== rtl/admr_level_ramp.sv ====
// One channel attenuator that steps toward its target level
`timescale 1ns/1ns
module admr_level_ramp
  import admr_pkg::*;
(
  input  wire logic       sys_clk,   // System clock
  input  wire logic       rst,       // Asynchronous reset, active high
  input  wire logic       stepTick,  // One step allowed this cycle
  input  wire logic       muteReq,   // Ramp toward mute
  input  wire logic [7:0] target,    // Loaded level code
  output logic      [7:0] level,     // Present level code
  output logic            muted      // Level gives infinite attenuation
);
  // Goal is mute or the loaded level
  wire [7:0] goal = muteReq ? ZERO_CODE : target;

  // One half-decibel step per tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level <= LEVEL_RESET;
    end else if (stepTick) begin
      if (level < goal) begin
        level <= level + 8'h01;
      end else if (level > goal) begin
        level <= level - 8'h01;
      end
    end
  end

  // Codes 0 to 14 mean infinite attenuation
  assign muted = (level <= MUTE_CODE_MAX);
endmodule

// ==== testbench/admr_regs_monitor.sv ====
// Port checks for the mode register bank
`timescale 1ns/1ns
module admr_regs_monitor
  import admr_pkg::*;
#(
  parameter logic [CHIPNUM_W-1:0] CHIP_NUMBER = 5'h00 // Arbitrary
)(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] cmdWord,
  input wire logic        cmdValid,
  input wire logic [15:0] readWord,
  input wire logic        readValid,
  input wire logic [7:0]  leftLevelCode,
  input wire logic        leftMuted,
  input wire logic        oneBitStreamMode,
  input wire logic        filterBypass
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Read request with a valid index prefix
  wire readReq = cmdValid && cmdWord[DIR_BIT]
    && cmdWord[IDX_HI:IDX_PFX_LO] == INDEX_PREFIX;
  wire [6:0] ansIdx = readWord[IDX_HI:IDX_LO]; // Index echoed back
  sequence s_read_req;
    readReq;
  endsequence
  sequence s_read_ans;
    readValid && readWord[15:8] == $past(cmdWord[15:8]);
  endsequence
  property p_read_answer;
    s_read_req |=> s_read_ans;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read request got no answer");
  property p_no_spurious;
    !readReq |=> !readValid;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer without a valid read");
  property p_stat_reserved;
    readValid && ansIdx == REG_ZERO_STAT |-> readWord[7:2] == 6'h00;
  endproperty
  a_stat_reserved: assert property (p_stat_reserved)
    else $error("zero status spare bits set");
  property p_ctrl_reserved;
    readValid && ansIdx == REG_ZERO_CTRL |-> readWord[7:3] == 5'h00;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("zero control spare bits set");
  property p_chip_number;
    readValid && ansIdx == REG_CHIP_NUM |->
      readWord[7:0] == {3'h0, CHIP_NUMBER};
  endproperty
  a_chip_number: assert property (p_chip_number)
    else $error("chip number readback wrong");
  property p_mute_flag;
    leftMuted == (leftLevelCode <= MUTE_CODE_MAX);
  endproperty
  a_mute_flag: assert property (p_mute_flag)
    else $error("mute flag disagrees with level");
  property p_step_one;
    !$stable(leftLevelCode) |->
      8'(leftLevelCode - $past(leftLevelCode)) inside {8'h01, 8'hff};
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("level moved more than one code");
  property p_mode_excl;
    !(oneBitStreamMode && filterBypass);
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("one-bit and bypass both active");
endmodule
bind admr_regs admr_regs_monitor #(.CHIP_NUMBER(CHIP_NUMBER)) u_mon (
  .sys_clk(sys_clk), .rst(rst), .cmdWord(cmdWord), .cmdValid(cmdValid),
  .readWord(readWord), .readValid(readValid),
  .leftLevelCode(leftLevelCode), .leftMuted(leftMuted),
  .oneBitStreamMode(oneBitStreamMode), .filterBypass(filterBypass));

// ==== testbench/admr_host_model.sv ====
// Host controller model on the serial control port
`timescale 1ns/1ns
module admr_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] readWord,
  input  wire logic        readValid,
  output logic      [15:0] cmdWord,
  output logic             cmdValid
);
  initial begin
    cmdWord  = 16'h0000;
    cmdValid = 1'b0;
  end
  // One word per strobe; lines scrambled after release
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk);
    #1;
    cmdWord  = w;
    cmdValid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    cmdWord  = ~w; // No stale word after release
  endtask
  // Read request, then bounded wait for the one-cycle answer
  task automatic fetch(input logic [6:0] idx, output logic [15:0] got,
                       output logic ok);
    int i;
    ok  = 1'b0;
    got = 16'h0000;
    send({1'b1, idx, 8'h00});
    for (i = 0; i < 4 && !ok; i++) begin
      if (readValid === 1'b1) begin
        got = readWord;
        ok  = 1'b1;
      end else begin
        @(posedge sys_clk);
        #1;
      end
    end
  endtask
endmodule

// ==== testbench/audio_dac_mode_registers_test.sv ====
// Register-level test of the mode register bank
`timescale 1ns/1ns
module audio_dac_mode_registers_test;
  import admr_pkg::*;
  logic sys_clk, rst, cmdValid, readValid, wordClockTick;
  logic leftZeroIn, rightZeroIn, leftMuted, rightMuted, oneBit, bypass;
  logic single, pick, softRst, endless, szero;
  logic [15:0] cmdWord, readWord;
  logic [7:0] leftLvl, rightLvl;
  logic [1:0] osr, firRate, firPerf, ozero, tickCnt, dmRate;
  logic [2:0] fmtSel;
  logic deEn, sMute, phInv, outDis, bStereo, roll;
  int miscompares, comparisons, i;
  logic [7:0] resetVals [8] = '{8'hff, 8'hff, 8'h50, 8'h00,
                                8'h40, 8'h01, 8'h00, 8'h0b};
  logic [7:0] modes [5] = '{8'h20, 8'h10, 8'h30, 8'h0e, 8'h00};
  admr_regs #(.CHIP_NUMBER(5'h0b)) uut ( // Chip number arbitrary
    .sys_clk(sys_clk), .rst(rst), .cmdWord(cmdWord),
    .cmdValid(cmdValid), .wordClockTick(wordClockTick),
    .leftZeroIn(leftZeroIn), .rightZeroIn(rightZeroIn),
    .readWord(readWord), .readValid(readValid),
    .leftLevelCode(leftLvl), .rightLevelCode(rightLvl),
    .leftMuted(leftMuted), .rightMuted(rightMuted),
    .serialFormatSelect(fmtSel), .deemphRateSelect(dmRate),
    .analogFirPerf(firPerf),
    .deemphEnable(deEn), .softMute(sMute), .phaseInvert(phInv),
    .outputDisable(outDis),
    .bypassStereoSelect(bStereo), .rolloffSelect(roll),
    .endlessZeroMute(endless),
    .softResetCtrl(softRst), .oneBitStreamMode(oneBit),
    .filterBypass(bypass), .singleChannelMode(single),
    .singleChannelPick(pick), .oversamplingRate(osr),
    .analogFirRate(firRate), .sampleZeroOutputEnable(szero),
    .onebitZeroOutput(ozero));
  admr_host_model u_host (.sys_clk(sys_clk), .readWord(readWord),
    .readValid(readValid), .cmdWord(cmdWord), .cmdValid(cmdValid));
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  // Word clock pulse every fourth cycle
  always @(posedge sys_clk) begin
    #1;
    wordClockTick = (tickCnt == 2'h0);
    tickCnt = tickCnt + 2'h1;
  end
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    u_host.send({1'b0, idx, d});
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    logic [15:0] got;
    logic ok;
    u_host.fetch(idx, got, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end else begin
      check("readWord", got, {1'b1, idx, e});
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge sys_clk);
    #1;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    tickCnt = 2'h0;
    wordClockTick = 1'b0;
    leftZeroIn = 1'b0;
    rightZeroIn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (i = 0; i < 8; i++) rd(7'(16 + i), resetVals[i]);
    check("szero", szero, 1);
    wr(REG_ZERO_STAT, 8'hff);
    wr(REG_CHIP_NUM, 8'hff);
    rd(REG_ZERO_STAT, 8'h00);
    rd(REG_CHIP_NUM, 8'h0b);
    wr(REG_ZERO_CTRL, 8'hfe);
    rd(REG_ZERO_CTRL, 8'h06);
    check("ozero", {ozero, szero}, 3'h6);
    wr(REG_OUTPUT, 8'hff);
    rd(REG_OUTPUT, 8'hf7);
    check("endless", endless, 1);
    check("outOpts", {phInv, outDis, bStereo, roll}, 4'hf);
    wr(REG_OUTPUT, 8'h00);
    wr(REG_FORMAT, 8'h5c);
    check("fmt", {fmtSel, deEn, sMute}, 5'h14);
    // Mode table, one-bit and bypass conflict included
    for (i = 0; i < 5; i++) begin
      wr(REG_MODE, modes[i]);
      rd(REG_MODE, modes[i]);
      check("oneBit", oneBit, modes[i][5] & !modes[i][4]);
      check("bypass", bypass, modes[i][4] & !modes[i][5]);
      check("single_channel_mode", {single, pick}, modes[i][3:2]);
      check("softRst", softRst, !modes[i][6]);
      if (modes[i][5] && !modes[i][4]) begin
        check("fir", {firPerf, firRate}, {2'h3, modes[i][1:0]});
        check("dmRate", dmRate, 2'h0);
      end else begin
        check("osr", osr, modes[i][1:0]);
        check("dmRate", dmRate, 2'h3);
      end
    end
    wr(REG_MODE, 8'h40);
    u_host.send(16'h5000);
    rd(REG_LEFT_LEVEL, 8'hff);
    leftZeroIn = 1'b1;
    rd(REG_ZERO_STAT, 8'h01);
    leftZeroIn = 1'b0;
    rightZeroIn = 1'b1;
    rd(REG_ZERO_STAT, 8'h02);
    rightZeroIn = 1'b0;
    wr(REG_FORMAT, 8'h50);
    wr(REG_LEFT_LEVEL, 8'h80);
    ticks(20);
    check("leftHeld", leftLvl, 8'hff);
    wr(REG_FORMAT, 8'hd0);
    wr(REG_LEFT_LEVEL, 8'h0e);
    wr(REG_RIGHT_LEVEL, 8'hf0);
    ticks(260);
    check("left", {leftMuted, leftLvl}, 9'h10e);
    check("right", {rightMuted, rightLvl}, 9'h0f0);
    wr(REG_OUTPUT, 8'h60);
    wr(REG_LEFT_LEVEL, 8'h1e);
    ticks(100);
    check("leftSlow", leftLvl < 8'h1e, 1);
    ticks(40);
    check("leftRamp", leftLvl, 8'h1e);
    wr(REG_FORMAT, 8'h50);
    wr(REG_LEFT_LEVEL, 8'hff);
    ticks(20);
    check("leftKept", leftLvl, 8'h1e);
    report_and_stop();
  end
endmodule
